/* sdl_pkg.sv */
`default_nettype none

package sdl_pkg;

	////////////////////////////////////////////////////////////////////////
	// frame and memory geometry
	localparam int ADDR_W    = 11;
	localparam int DATA_W    = 12;
	localparam int FRAME_W   = ADDR_W + DATA_W;
	localparam int MEM_DEPTH = 2048;
	localparam int FIFO_DEPTH = 16;

	////////////////////////////////////////////////////////////////////////
	// programming pins, index into the pin vector
	localparam int PIN_COUNT = 4;
	localparam int PIN_EN    = 0;
	localparam int PIN_CLK   = 1;
	localparam int PIN_DAT   = 2;
	localparam int PIN_LCH   = 3;

	////////////////////////////////////////////////////////////////////////
	// filter clock is the system clock divided by sixteen
	localparam int DIV_W              = 4;
	localparam logic [DIV_W-1:0] DIV_LAST = 4'hF;
	localparam logic [DIV_W-1:0] DIV_INIT = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sdl_frame_s;

	typedef enum logic [3:0] {
		F_LOW  = 4'h1,
		F_RISE = 4'h2,
		F_HIGH = 4'h4,
		F_FALL = 4'h8
	} sdl_filt_e;

	typedef enum logic [2:0] {
		W_IDLE = 3'h1,
		W_PUSH = 3'h2,
		W_WAIT = 3'h4
	} sdl_wsm_e;

endpackage

`default_nettype wire

/* sdl_input_glitch_filter.sv */
`timescale 1ns/10ps
`default_nettype none

module sdl_input_glitch_filter (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic ce,
	// filter clock enable
	input  wire logic tick,
	// signal
	input  wire logic din,
	output logic      dout
);

	logic               samp;
	sdl_pkg::sdl_filt_e state;

	////////////////////////////////////////////////////////////////////////
	// single sample register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			samp <= 1'b0;
		end else if (ce && tick) begin
			samp <= din;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= sdl_pkg::F_LOW;
		end else if (ce && tick) begin
			case (state)
				sdl_pkg::F_LOW: begin
					state <= samp ? sdl_pkg::F_RISE : sdl_pkg::F_LOW;
				end
				sdl_pkg::F_RISE: begin
					state <= samp ? sdl_pkg::F_HIGH : sdl_pkg::F_LOW;
				end
				sdl_pkg::F_HIGH: begin
					state <= samp ? sdl_pkg::F_HIGH : sdl_pkg::F_FALL;
				end
				sdl_pkg::F_FALL: begin
					state <= samp ? sdl_pkg::F_HIGH : sdl_pkg::F_LOW;
				end
				default: begin
					state <= sdl_pkg::F_LOW;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dout <= 1'b0;
		end else if (ce) begin
			dout <= (state == sdl_pkg::F_HIGH) || (state == sdl_pkg::F_FALL);
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_sample_tick: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && tick) |=> (samp == $past(din))) else $error("sample not taken on tick");

	a_short_reject: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && tick && state == sdl_pkg::F_RISE && !samp) |=> ##1 !dout)
		else $error("one-tick pulse passed filter");

	a_rise_held: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(dout) |-> $past(samp, 2)) else $error("output rose without held input");

endmodule

`default_nettype wire

/* sdl_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module sdl_fifo #(
	parameter int WIDTH = 23,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] NONE = '0;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != FULL);
	assign out_valid = (count != NONE);
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

/* sdl_download_interface.sv */
`timescale 1ns/10ps
`default_nettype none

module sdl_download_interface (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	// programming pins, active low
	input  wire logic                          download_enable_n,
	input  wire logic                          shift_clock_n,
	input  wire logic                          serial_bit_in_n,
	input  wire logic                          latch_strobe_n,
	// core side
	input  wire logic [sdl_pkg::ADDR_W-1:0]    pc_addr,
	output logic                               core_hold,
	output logic [sdl_pkg::DATA_W-1:0]         instr_word
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [sdl_pkg::PIN_COUNT-1:0] pins;
	logic [sdl_pkg::PIN_COUNT-1:0] sync1;
	logic [sdl_pkg::PIN_COUNT-1:0] sync2;
	logic [sdl_pkg::PIN_COUNT-1:0] filt;
	logic [sdl_pkg::DIV_W-1:0]     div_cnt;
	logic                          tick;
	logic                          enable_f;
	logic                          sclk_f;
	logic                          sbit_f;
	logic                          latch_f;
	logic                          sclk_prev;
	logic                          clk_rise;
	logic [sdl_pkg::FRAME_W-1:0]   shreg;
	sdl_pkg::sdl_wsm_e             wsm;
	logic                          fifo_in_valid;
	logic                          fifo_in_ready;
	logic                          fifo_out_valid;
	logic                          fifo_out_ready;
	logic [sdl_pkg::FRAME_W-1:0]   fifo_out_data;
	sdl_pkg::sdl_frame_s           pop_frame;
	logic                          mem_we;
	logic [sdl_pkg::ADDR_W-1:0]    wr_addr;
	logic [sdl_pkg::DATA_W-1:0]    wr_data;
	logic [sdl_pkg::ADDR_W-1:0]    mem_addr;
	logic                          busy;
	logic [sdl_pkg::DATA_W-1:0]    imem [sdl_pkg::MEM_DEPTH];

	assign pins[sdl_pkg::PIN_EN]  = download_enable_n;
	assign pins[sdl_pkg::PIN_CLK] = shift_clock_n;
	assign pins[sdl_pkg::PIN_DAT] = serial_bit_in_n;
	assign pins[sdl_pkg::PIN_LCH] = latch_strobe_n;

	////////////////////////////////////////////////////////////////////////
	// filter clock enable
	// divide by sixteen
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			div_cnt <= sdl_pkg::DIV_INIT;
		end else if (ce) begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	assign tick = (div_cnt == sdl_pkg::DIV_LAST);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and filters
	genvar i;
	generate
		for (i = 0; i < sdl_pkg::PIN_COUNT; i++) begin : g_pin
			// pins idle high, so the synchroniser resets to idle
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					sync1[i] <= 1'b1;
					sync2[i] <= 1'b1;
				end else if (ce) begin
					sync1[i] <= pins[i];
					sync2[i] <= sync1[i];
				end
			end

			sdl_input_glitch_filter u_filter (
				.sys_clk (sys_clk),
				.resetn  (resetn),
				.ce      (ce),
				.tick    (tick),
				.din     (~sync2[i]),
				.dout    (filt[i])
			);
		end
	endgenerate

	assign enable_f = filt[sdl_pkg::PIN_EN];
	assign sclk_f   = filt[sdl_pkg::PIN_CLK];
	assign sbit_f   = filt[sdl_pkg::PIN_DAT];
	assign latch_f  = filt[sdl_pkg::PIN_LCH];

	////////////////////////////////////////////////////////////////////////
	// shift register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sclk_prev <= 1'b0;
		end else if (ce) begin
			sclk_prev <= sclk_f;
		end
	end

	assign clk_rise = sclk_f && !sclk_prev;

	// first bit ends up as address MSB
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			shreg <= '0;
		end else if (ce && enable_f && clk_rise) begin
			shreg <= {shreg[sdl_pkg::FRAME_W-2:0], sbit_f};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write-pulse state machine
	// one frame per strobe
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wsm <= sdl_pkg::W_IDLE;
		end else if (ce) begin
			case (wsm)
				sdl_pkg::W_IDLE: begin
					if (latch_f && enable_f) begin
						wsm <= sdl_pkg::W_PUSH;
					end
				end
				sdl_pkg::W_PUSH: begin
					if (fifo_in_ready) begin
						wsm <= sdl_pkg::W_WAIT;
					end
				end
				sdl_pkg::W_WAIT: begin
					if (!latch_f) begin
						wsm <= sdl_pkg::W_IDLE;
					end
				end
				default: begin
					wsm <= sdl_pkg::W_IDLE;
				end
			endcase
		end
	end

	assign fifo_in_valid = (wsm == sdl_pkg::W_PUSH);

	// full queue stalls the machine in push, so no frame is dropped
	sdl_fifo #(
		.WIDTH (sdl_pkg::FRAME_W),
		.DEPTH (sdl_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.ce        (ce),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (shreg),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign pop_frame      = sdl_pkg::sdl_frame_s'(fifo_out_data);
	assign fifo_out_ready = !mem_we;

	////////////////////////////////////////////////////////////////////////
	// instruction memory write
	// single-cycle write pulse
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mem_we  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else if (ce) begin
			mem_we <= fifo_out_valid && fifo_out_ready;
			if (fifo_out_valid && fifo_out_ready) begin
				wr_addr <= pop_frame.addr;
				wr_data <= pop_frame.data;
			end
		end
	end

	// write port of the instruction memory
	always_ff @(posedge sys_clk) begin
		if (ce && mem_we) begin
			imem[wr_addr] <= wr_data;
		end
	end

	assign instr_word = imem[mem_addr];

	////////////////////////////////////////////////////////////////////////
	// core reset and address source
	// hold stays up until queued frames are written, so none is lost
	assign busy = (wsm != sdl_pkg::W_IDLE) || fifo_out_valid || mem_we;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			core_hold <= 1'b0;
		end else if (ce) begin
			core_hold <= enable_f || busy;
		end
	end

	assign mem_addr = core_hold ? wr_addr : pc_addr;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && !enable_f && !busy) |=> !core_hold) else $error("hold without download");

	a_pc_source: assert property (@(posedge sys_clk) disable iff (!resetn)
		!core_hold |-> (mem_addr == pc_addr)) else $error("memory not addressed by pc");

	a_hold_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && enable_f) |=> (core_hold && mem_addr == wr_addr))
		else $error("download not holding core");

	a_shift_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && enable_f && clk_rise) |=> (shreg[0] == $past(sbit_f)))
		else $error("bit not shifted on edge");

	a_latch_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && wsm == sdl_pkg::W_PUSH && fifo_in_ready) |-> ##[1:40] mem_we)
		else $error("latched frame never written");

	a_one_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && mem_we) |=> !mem_we) else $error("write pulse longer than one cycle");

	a_one_push: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && wsm == sdl_pkg::W_WAIT && latch_f) |=> (wsm != sdl_pkg::W_PUSH))
		else $error("second frame from one strobe");

	a_release: assert property (@(posedge sys_clk) disable iff (!resetn)
		$fell(core_hold) |-> (!$past(enable_f) && mem_addr == pc_addr))
		else $error("release while enable active");

	a_div_tick: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && tick) |=> !tick) else $error("filter tick too often");

	////////////////////////////////////////////////////////////////////////
	// filter clock checks
	// resetn in the antecedent keeps the release edge, where the count restarts, out
	a_div_step: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && resetn) |=> (div_cnt == $past(div_cnt) + 1'b1))
		else $error("filter divider skipped a count");

	a_div_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!ce && resetn) |=> $stable(div_cnt))
		else $error("filter divider moved while frozen");

	////////////////////////////////////////////////////////////////////////
	// shift register checks
	a_shift_whole: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && enable_f && clk_rise) |=>
		(shreg[sdl_pkg::FRAME_W-1:1] == $past(shreg[sdl_pkg::FRAME_W-2:0])))
		else $error("older bits not moved up");

	a_shift_refuse: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(ce && enable_f && clk_rise) |=> $stable(shreg))
		else $error("bit taken without download edge");

	a_edge_once: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && clk_rise) |=> !clk_rise)
		else $error("shift edge seen twice");

	////////////////////////////////////////////////////////////////////////
	// write machine and memory write checks
	a_latch_take: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && wsm == sdl_pkg::W_IDLE && latch_f && enable_f) |=> (wsm == sdl_pkg::W_PUSH))
		else $error("latch not taken");

	a_idle_stay: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && wsm == sdl_pkg::W_IDLE && !(latch_f && enable_f)) |=> (wsm == sdl_pkg::W_IDLE))
		else $error("frame queued without latch");

	a_push_done: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && wsm == sdl_pkg::W_PUSH && fifo_in_ready) |=> (wsm == sdl_pkg::W_WAIT))
		else $error("push not followed by wait");

	a_wait_release: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && wsm == sdl_pkg::W_WAIT && !latch_f) |=> (wsm == sdl_pkg::W_IDLE))
		else $error("strobe release not seen");

	a_wait_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		(wsm == sdl_pkg::W_WAIT) |-> core_hold)
		else $error("core released during a write");

	a_hold_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && busy) |=> core_hold)
		else $error("core released with writes pending");

	a_pop_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		(ce && fifo_out_valid && fifo_out_ready) |=>
		(mem_we && {wr_addr, wr_data} == $past(fifo_out_data)))
		else $error("popped frame not written");

	a_write_regs: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(ce && fifo_out_valid && fifo_out_ready) |=> ($stable(wr_addr) && $stable(wr_data)))
		else $error("write registers moved without pop");

	////////////////////////////////////////////////////////////////////////
	// reset checks, deliberately without a disable
	a_reset_hold: assert property (@(posedge sys_clk)
		!resetn |=> !core_hold)
		else $error("core held after reset");

	a_reset_wsm: assert property (@(posedge sys_clk)
		!resetn |=> (wsm == sdl_pkg::W_IDLE && !mem_we))
		else $error("write machine not idle after reset");

	a_reset_shift: assert property (@(posedge sys_clk)
		!resetn |=> (shreg == '0 && !clk_rise))
		else $error("shift state not cleared by reset");

endmodule

`default_nettype wire

/* sdl_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module sdl_host_model #(
	parameter int PHASE = 64
) (
	// clock
	input  wire logic sys_clk,
	// programming pins, active low
	output logic      download_enable_n,
	output logic      shift_clock_n,
	output logic      serial_bit_in_n,
	output logic      latch_strobe_n
);

	initial begin
		download_enable_n = 1'b1;
		shift_clock_n     = 1'b1;
		serial_bit_in_n   = 1'b1;
		latch_strobe_n    = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// enable level change
	task automatic set_enable(input logic on);
		download_enable_n <= ~on;
		wait_clk(2 * PHASE);
	endtask

	task automatic set_latch(input logic on);
		latch_strobe_n <= ~on;
		wait_clk(2 * PHASE);
	endtask

	task automatic shift_frame(input sdl_pkg::sdl_frame_s f, input int glitch_at);
		for (int i = sdl_pkg::FRAME_W - 1; i >= 0; i--) begin
			serial_bit_in_n <= ~f[i];
			if (i == glitch_at) begin
				// four cycles, half a phase into the bit, well under one filter tick
				wait_clk(PHASE / 2);
				shift_clock_n <= 1'b0;
				wait_clk(4);
				shift_clock_n <= 1'b1;
				wait_clk(PHASE / 2 - 4);
			end else begin
				wait_clk(PHASE);
			end
			shift_clock_n <= 1'b0;
			wait_clk(PHASE);
			shift_clock_n <= 1'b1;
		end
		// stale data must not look like a valid bit
		serial_bit_in_n <= f[0];
		wait_clk(PHASE);
	endtask

	task automatic glitch(input int pin);
		if (pin == sdl_pkg::PIN_EN)
			download_enable_n <= 1'b0;
		else
			latch_strobe_n <= 1'b0;
		wait_clk(4);
		if (pin == sdl_pkg::PIN_EN)
			download_enable_n <= 1'b1;
		else
			latch_strobe_n <= 1'b1;
		wait_clk(2 * PHASE);
	endtask

endmodule

`default_nettype wire

/* sdl_download_interface_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module sdl_download_interface_tb;

	localparam int PHASE = 64;
	localparam int LIMIT = 80000;
	localparam int FW    = sdl_pkg::FRAME_W;
	localparam int AW    = sdl_pkg::ADDR_W;

	logic                        sys_clk;
	logic                        resetn;
	logic                        ce;
	logic [AW-1:0]               pc_addr;
	logic                        download_enable_n;
	logic                        shift_clock_n;
	logic                        serial_bit_in_n;
	logic                        latch_strobe_n;
	logic                        core_hold;
	logic [sdl_pkg::DATA_W-1:0]  instr_word;
	int                          n_mismatch = 0;
	int                          checks     = 0;
	int                          cycles     = 0;
	int                          bad        = 0;
	int                          seed       = 32'h49BA4BB3;
	logic [sdl_pkg::DATA_W-1:0]  exp_mem [logic [AW-1:0]];

	sdl_download_interface i_sdl_download_interface (
		.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
		.download_enable_n(download_enable_n), .shift_clock_n(shift_clock_n),
		.serial_bit_in_n(serial_bit_in_n), .latch_strobe_n(latch_strobe_n),
		.pc_addr(pc_addr), .core_hold(core_hold), .instr_word(instr_word)
	);

	sdl_host_model #(.PHASE(PHASE)) i_sdl_host_model (
		.sys_clk(sys_clk), .download_enable_n(download_enable_n),
		.shift_clock_n(shift_clock_n), .serial_bit_in_n(serial_bit_in_n),
		.latch_strobe_n(latch_strobe_n)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_mismatch++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [FW-1:0] got, input logic [FW-1:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic sdl_pkg::sdl_frame_s frame_of(input int a, input int d);
		frame_of.addr = a[AW-1:0];
		frame_of.data = d[sdl_pkg::DATA_W-1:0];
	endfunction

	task automatic wait_hold(input logic v);
		int k;
		k = 0;
		while (core_hold !== v && k < 6 * PHASE) begin
			@(posedge sys_clk);
			k++;
		end
		check(FW'(core_hold), FW'(v));
	endtask

	// live means the enable pin is asserted, so the word must land
	task automatic send(input sdl_pkg::sdl_frame_s f, input int glitch_at, input logic live);
		pc_addr <= AW'($random(seed));
		i_sdl_host_model.shift_frame(f, glitch_at);
		i_sdl_host_model.set_latch(1'b1);
		i_sdl_host_model.set_latch(1'b0);
		if (live)
			exp_mem[f.addr] = f.data;
		check(FW'(core_hold), FW'(live));
		// while held, memory is addressed by the last written location
		if (live)
			check(FW'(instr_word), FW'(f.data));
	endtask

	task automatic read_back();
		foreach (exp_mem[a]) begin
			pc_addr <= a;
			@(posedge sys_clk);
			check(FW'(instr_word), FW'(exp_mem[a]));
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	// one address twice in a row through the queue: the later word must win
	task automatic queue_test();
		send(frame_of('h155, 'hAAA), -1, 1'b1);
		send(frame_of('h155, 'h555), -1, 1'b1);
		check(FW'(instr_word), FW'(12'h555));
		pc_addr <= ~pc_addr;
		@(posedge sys_clk);
		check(FW'(instr_word), FW'(12'h555));
		check(FW'(core_hold), FW'(1));
		end_test("queue");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		resetn       = 1'b0;
		ce           = 1'b1;
		pc_addr      = 11'h000;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		check(FW'(core_hold), FW'(0));
		// a frozen clock enable must hold the download off
		ce <= 1'b0;
		i_sdl_host_model.set_enable(1'b1);
		check(FW'(core_hold), FW'(0));
		ce <= 1'b1;
		wait_hold(1'b1);
		end_test("enable");
		queue_test();
		send(frame_of(0, 'hFFF), -1, 1'b1);
		send(frame_of('h7FF, 'h000), -1, 1'b1);
		for (int i = 0; i < 8; i++)
			send(frame_of($random(seed), $random(seed)), (i == 3) ? 11 : -1, 1'b1);
		// strobe held over a whole new frame must write only once
		i_sdl_host_model.set_latch(1'b1);
		i_sdl_host_model.shift_frame(frame_of(0, 'h123), -1);
		i_sdl_host_model.set_latch(1'b0);
		i_sdl_host_model.shift_frame(frame_of('h7FF, 'h456), -1);
		i_sdl_host_model.glitch(sdl_pkg::PIN_LCH);
		send(frame_of($random(seed), $random(seed)), -1, 1'b1);
		i_sdl_host_model.set_enable(1'b0);
		wait_hold(1'b0);
		read_back();
		end_test("download");
		send(frame_of(0, 'hABC), -1, 1'b0);
		read_back();
		fork
			i_sdl_host_model.glitch(sdl_pkg::PIN_EN);
			repeat (2 * PHASE) begin
				@(posedge sys_clk);
				if (core_hold !== 1'b0)
					bad++;
			end
		join
		check(FW'(bad), FW'(0));
		end_test("refused");
		i_sdl_host_model.set_enable(1'b1);
		wait_hold(1'b1);
		send(frame_of($random(seed), $random(seed)), -1, 1'b1);
		i_sdl_host_model.set_enable(1'b0);
		wait_hold(1'b0);
		read_back();
		end_test("reload");
		give_verdict();
	end

endmodule

`default_nettype wire
